// >>> logic/nbh_defines.vh
// shared constants for the nand bus host controller
`ifndef NBH_DEFINES_VH
`define NBH_DEFINES_VH
`define NBH_CLK_PERIOD_PS      5000
`define NBH_T_WC_NS            25
`define NBH_T_RC_NS            30
`define NBH_T_WW_NS            100
`define NBH_T_RST_US           1000
`define NBH_T_PWR_US           100
`define NBH_CYC_WC             ((`NBH_T_WC_NS * 1000 + `NBH_CLK_PERIOD_PS - 1) / `NBH_CLK_PERIOD_PS)
`define NBH_CYC_RC             ((`NBH_T_RC_NS * 1000 + `NBH_CLK_PERIOD_PS - 1) / `NBH_CLK_PERIOD_PS)
`define NBH_CYC_WW             ((`NBH_T_WW_NS * 1000 + `NBH_CLK_PERIOD_PS - 1) / `NBH_CLK_PERIOD_PS)
`define NBH_CYC_RST            ((`NBH_T_RST_US * 1000000) / `NBH_CLK_PERIOD_PS)
`define NBH_CYC_PWR            ((`NBH_T_PWR_US * 1000000) / `NBH_CLK_PERIOD_PS)
`define NBH_CMD_RESET          8'hFF
`define NBH_CMD_READ_MODE      8'h00
`define NBH_CMD_STATUS         8'h70
`define NBH_CMD_STATUS_ENH     8'h78
`define NBH_OP_CMD             2'h0
`define NBH_OP_ADDR            2'h1
`define NBH_OP_WDATA           2'h2
`define NBH_OP_RDATA           2'h3
`define NBH_CA_HI_X8           11
`define NBH_CA_HI_X16          10
`define NBH_PLANE_BIT          6
`endif

// >>> logic/nbh_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module nbh_sync (
  input  wire sys_clk,
  input  wire rst_n,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a change counts only once stages two and three agree
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // nbh_sync
`default_nettype wire

// >>> logic/nbh_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module nbh_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp_reg;
  reg [AW:0]      rp_reg;
  wire            full  = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire            empty = (wp_reg == rp_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_reg[AW-1:0]];
  always @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule // nbh_fifo
`default_nettype wire

// >>> logic/nbh_host.v
// host controller that drives an asynchronous nand flash target
//
// Contract
// - command byte on low lane, cle high ale low, latched at we rising
// - address byte on low lane, ale high cle low, latched at we rising
// - write data with cle and ale low, latched at we rising
// - sample read data at re rise since read cycle is 30ns or longer
// - after enhanced status the host issues 00h before array data; the code only tracks 78h/00h in enh_reg and sends no 00h itself
// - x16 upper lane is zero during command cycles
// - commands and addresses only on low lane; upper lane data only
// - x8 five-cycle address layout; ca11 set forces ca10..6 zero
// - x16 address layout; ca10 set forces ca9..5 zero
// - host drives all out-of-space address bits to zero
// - write protect changes only when ready and idle, then wait tww
// - write protect held low from power-on until supply is stable
// - reset ffh first after power-on, target busy for 1ms
`timescale 1ns/1ps
`default_nettype none
`include "nbh_defines.vh"
module nbh_host #(
  parameter X16      = 0,
  parameter CYC_RST  = `NBH_CYC_RST,
  parameter CYC_PWR  = `NBH_CYC_PWR,
  parameter FIFO_DEP = 16
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [1:0]  req_op,
  input  wire [7:0]  req_byte,
  input  wire        req_last,
  input  wire [15:0] wr_data,
  input  wire        wr_valid,
  output wire        wr_ready,
  output wire [15:0] rd_data,
  output wire        rd_valid,
  input  wire        rd_ready,
  input  wire [11:0] addr_col,
  input  wire [16:0] addr_blk,
  input  wire [5:0]  addr_page,
  input  wire        addr_go,
  input  wire        wp_allow,
  output reg         init_done,
  output reg         target_ready,
  output reg         plane_sel,
  output reg         nand_ce_n,
  output reg         nand_cle,
  output reg         nand_ale,
  output reg         nand_we_n,
  output reg         nand_re_n,
  output reg         nand_wp_n,
  output reg  [15:0] nand_io_out,
  output reg         nand_io_oe_n,
  input  wire [15:0] nand_io_in,
  input  wire        nand_rb_n
);
  localparam S_PWR   = 4'h0;
  localparam S_RSTC  = 4'h1;
  localparam S_RSTW  = 4'h2;
  localparam S_IDLE  = 4'h3;
  localparam S_WLOW  = 4'h4;
  localparam S_WHIGH = 4'h5;
  localparam S_RLOW  = 4'h6;
  localparam S_RHIGH = 4'h7;
  localparam S_WPW   = 4'h8;
  localparam S_ADDR  = 4'h9;
  localparam HALF_WC = (`NBH_CYC_WC + 1) / 2;
  localparam HALF_RC = (`NBH_CYC_RC + 1) / 2;

  reg  rst_s1_reg;
  reg  rst_n_reg;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  wire rb_sync;
  nbh_sync u_rb (
    .sys_clk (sys_clk),
    .rst_n   (rst_n_reg),
    .din     (nand_rb_n),
    .dout    (rb_sync)
  );
  // io lines are only sampled while re is held, so one sync stage set suffices per bit
  wire [15:0] io_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_io
      nbh_sync u_io (
        .sys_clk (sys_clk),
        .rst_n   (rst_n_reg),
        .din     (nand_io_in[gi]),
        .dout    (io_sync[gi])
      );
    end
  endgenerate

  wire        fifo_in_ready;
  reg  [15:0] fifo_in_data_reg;
  reg         fifo_in_valid_reg;
  nbh_fifo #(.WIDTH(16), .DEPTH(FIFO_DEP), .AW(4)) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n_reg),
    .in_data   (fifo_in_data_reg),
    .in_valid  (fifo_in_valid_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );

  reg [3:0]  state_reg;
  reg [31:0] cnt_reg;
  reg [1:0]  op_reg;
  reg        last_reg;
  reg [2:0]  acyc_reg;
  reg [39:0] abuf_reg;
  reg        enh_reg;
  reg        wp_pending_reg;

  // mask column bits per width so unused bits go out as zero
  reg [11:0] col_clean;
  always @* begin
    col_clean = addr_col;
    if (X16 != 0) begin
      col_clean[11] = 1'b0;
      if (addr_col[`NBH_CA_HI_X16]) begin
        col_clean[9:5] = 5'h00;
      end
    end else if (addr_col[`NBH_CA_HI_X8]) begin
      col_clean[10:6] = 5'h00;
    end
  end
  wire [39:0] addr_pack = {7'h00, addr_blk[16], addr_blk[15:8], addr_blk[7:6], addr_page,
                           4'h0, col_clean[11:8], col_clean[7:0]};

  wire idle_ok = (state_reg == S_IDLE);
  // a protect change waits for ce high, so requests inside a sequence keep flowing instead of deadlocking
  assign req_ready = idle_ok && !(wp_pending_reg && nand_ce_n) &&
                     (req_op != `NBH_OP_RDATA || fifo_in_ready) &&
                     (req_op != `NBH_OP_WDATA || wr_valid);
  assign wr_ready  = req_ready && req_valid && req_op == `NBH_OP_WDATA;

  always @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg         <= S_PWR;
      cnt_reg           <= 32'h00000000;
      op_reg            <= 2'h0;
      last_reg          <= 1'b0;
      acyc_reg          <= 3'h0;
      abuf_reg          <= 40'h0000000000;
      enh_reg           <= 1'b0;
      wp_pending_reg    <= 1'b0;
      init_done         <= 1'b0;
      target_ready      <= 1'b0;
      plane_sel         <= 1'b0;
      nand_ce_n         <= 1'b1;
      nand_cle          <= 1'b0;
      nand_ale          <= 1'b0;
      nand_we_n         <= 1'b1;
      nand_re_n         <= 1'b1;
      nand_wp_n         <= 1'b0;
      nand_io_out       <= 16'h0000;
      nand_io_oe_n      <= 1'b1;
      fifo_in_data_reg  <= 16'h0000;
      fifo_in_valid_reg <= 1'b0;
    end else begin
      fifo_in_valid_reg <= 1'b0;
      target_ready      <= rb_sync;
      if (wp_allow != nand_wp_n && init_done) begin
        wp_pending_reg <= 1'b1;
      end
      case (state_reg)
        S_PWR: begin
          if (cnt_reg >= CYC_PWR - 1 && rb_sync) begin
            cnt_reg     <= 32'h00000000;
            state_reg   <= S_RSTC;
          end else if (cnt_reg < CYC_PWR - 1) begin
            cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        S_RSTC: begin
          nand_ce_n    <= 1'b0;
          nand_cle     <= 1'b1;
          nand_io_out  <= {8'h00, `NBH_CMD_RESET};
          nand_io_oe_n <= 1'b0;
          op_reg       <= `NBH_OP_CMD;
          last_reg     <= 1'b1;
          cnt_reg      <= 32'h00000000;
          nand_we_n    <= 1'b0;
          state_reg    <= S_WLOW;
        end
        S_RSTW: begin
          // reset busy time is waited out in full, and ready/busy must then also show ready
          if (cnt_reg >= CYC_RST - 1 && rb_sync) begin
            init_done <= 1'b1;
            state_reg <= S_IDLE;
          end else if (cnt_reg < CYC_RST - 1) begin
            cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        S_IDLE: begin
          nand_cle <= 1'b0;
          nand_ale <= 1'b0;
          if (wp_pending_reg && nand_ce_n) begin
            // only between sequences and with the target ready
            if (rb_sync) begin
              nand_wp_n      <= wp_allow;
              cnt_reg        <= 32'h00000000;
              state_reg      <= S_WPW;
            end
          end else if (req_valid && req_ready) begin
            op_reg   <= req_op;
            last_reg <= req_last;
            cnt_reg  <= 32'h00000000;
            nand_ce_n <= 1'b0;
            case (req_op)
              `NBH_OP_CMD: begin
                nand_cle     <= 1'b1;
                nand_io_out  <= {8'h00, req_byte};
                nand_io_oe_n <= 1'b0;
                nand_we_n    <= 1'b0;
                if (req_byte == `NBH_CMD_STATUS_ENH) begin
                  enh_reg <= 1'b1;
                end else if (req_byte == `NBH_CMD_READ_MODE) begin
                  enh_reg <= 1'b0;
                end
                state_reg    <= S_WLOW;
              end
              `NBH_OP_ADDR: begin
                nand_ale     <= 1'b1;
                nand_io_out  <= {8'h00, req_byte};
                nand_io_oe_n <= 1'b0;
                nand_we_n    <= 1'b0;
                state_reg    <= S_WLOW;
              end
              `NBH_OP_WDATA: begin
                nand_io_out  <= (X16 != 0) ? wr_data : {8'h00, wr_data[7:0]};
                nand_io_oe_n <= 1'b0;
                nand_we_n    <= 1'b0;
                state_reg    <= S_WLOW;
              end
              default: begin
                nand_io_oe_n <= 1'b1;
                nand_re_n    <= 1'b0;
                state_reg    <= S_RLOW;
              end
            endcase
          end else if (addr_go) begin
            // a level request: it waits while an accepted handshake is served first
            abuf_reg  <= addr_pack;
            plane_sel <= addr_blk[`NBH_PLANE_BIT];
            acyc_reg  <= 3'h0;
            state_reg <= S_ADDR;
          end
        end
        S_ADDR: begin
          nand_ce_n    <= 1'b0;
          nand_ale     <= 1'b1;
          nand_io_out  <= {8'h00, abuf_reg[7:0]};
          nand_io_oe_n <= 1'b0;
          nand_we_n    <= 1'b0;
          abuf_reg     <= {8'h00, abuf_reg[39:8]};
          op_reg       <= `NBH_OP_ADDR;
          last_reg     <= 1'b0;
          cnt_reg      <= 32'h00000000;
          acyc_reg     <= acyc_reg + 3'h1;
          state_reg    <= S_WLOW;
        end
        S_WLOW: begin
          if (cnt_reg >= HALF_WC - 1) begin
            nand_we_n <= 1'b1;
            cnt_reg   <= 32'h00000000;
            state_reg <= S_WHIGH;
          end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        S_WHIGH: begin
          if (cnt_reg >= HALF_WC - 1) begin
            nand_cle     <= 1'b0;
            nand_ale     <= 1'b0;
            nand_io_oe_n <= 1'b1;
            cnt_reg      <= 32'h00000000;
            if (!init_done) begin
              // ce high through the reset busy time frees the shared bus
              nand_ce_n <= 1'b1;
              state_reg <= S_RSTW;
            end else if (op_reg == `NBH_OP_ADDR && acyc_reg != 3'h0 && acyc_reg != 3'h5) begin
              state_reg <= S_ADDR;
            end else begin
              acyc_reg  <= 3'h0;
              // releasing ce frees the shared bus while the target works
              nand_ce_n <= last_reg;
              state_reg <= S_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        S_RLOW: begin
          if (cnt_reg >= HALF_RC + 2) begin
            nand_re_n <= 1'b1;
            // data captured at re rise; period is at least 30ns
            fifo_in_data_reg  <= (X16 != 0) ? io_sync : {8'h00, io_sync[7:0]};
            fifo_in_valid_reg <= 1'b1;
            cnt_reg   <= 32'h00000000;
            state_reg <= S_RHIGH;
          end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        S_RHIGH: begin
          if (cnt_reg >= HALF_RC - 1) begin
            nand_ce_n <= last_reg;
            cnt_reg   <= 32'h00000000;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        S_WPW: begin
          if (cnt_reg >= `NBH_CYC_WW - 1) begin
            // a new change arriving in this cycle keeps the flag set
            wp_pending_reg <= (wp_allow != nand_wp_n);
            state_reg      <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // nbh_host
`default_nettype wire

// >>> test/nbh_sva.sv
// pin-level assertions for the nand host controller
`timescale 1ns/1ps
`default_nettype none
module nbh_sva (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [1:0]  req_op,
  input wire logic        init_done,
  input wire logic        nand_ce_n,
  input wire logic        nand_cle,
  input wire logic        nand_ale,
  input wire logic        nand_we_n,
  input wire logic        nand_re_n,
  input wire logic        nand_wp_n,
  input wire logic [15:0] nand_io_out,
  input wire logic        nand_io_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_we_low; (!nand_we_n)[*3]; endsequence
  sequence s_we_high; nand_we_n; endsequence
  property p_we_pulse; $fell(nand_we_n) |-> s_we_low ##1 s_we_high; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe low phase wrong");
  property p_cmd; $rose(nand_we_n) && nand_cle |-> !nand_ce_n && !nand_ale && nand_re_n && !nand_io_oe_n;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command latch qualifiers wrong");
  property p_adr; $rose(nand_we_n) && nand_ale |-> !nand_ce_n && !nand_cle && nand_io_out[15:8] == 8'h00;
  endproperty
  a_adr: assert property (p_adr) else $error("address latch qualifiers wrong");
  property p_dat; $rose(nand_we_n) && !nand_cle && !nand_ale |-> !nand_ce_n && nand_re_n && !nand_io_oe_n;
  endproperty
  a_dat: assert property (p_dat) else $error("data input qualifiers wrong");
  property p_cmd_hi; nand_cle && !nand_io_oe_n |-> nand_io_out[15:8] == 8'h00; endproperty
  a_cmd_hi: assert property (p_cmd_hi) else $error("upper lane not zero on command");
  property p_rd; !nand_re_n |-> nand_io_oe_n && nand_we_n && !nand_cle && !nand_ale && !nand_ce_n; endproperty
  a_rd: assert property (p_rd) else $error("read strobe while driving or latching");
  property p_wp; $changed(nand_wp_n) |-> nand_ce_n[*8]; endproperty
  a_wp: assert property (p_wp) else $error("command too soon around protect change");
  property p_wp_init; !init_done |-> !nand_wp_n; endproperty
  a_wp_init: assert property (p_wp_init) else $error("protect released before init");
  property p_take; req_valid && req_ready && !req_op[1] |=> !nand_ce_n && !nand_we_n; endproperty
  a_take: assert property (p_take) else $error("accepted cycle did not start");
endmodule // nbh_sva
`default_nettype wire

// >>> test/nbh_flash_model.sv
// behavioural nand target facing the host, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module nbh_flash_model #(parameter int BUSY = 40) (
  input  wire logic        clk,
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        re_n,
  input  wire logic        wp_n,
  input  wire logic [15:0] io,
  output logic      [15:0] dout,
  output logic             rb_n
);
  logic [7:0]  cmd;
  logic [7:0]  adr [0:4];
  logic [15:0] mem [0:15];
  logic        we_q, re_q;
  int          na, wi, ri, busy, ncmd;
  initial begin
    cmd = 8'h00; we_q = 1'b1; re_q = 1'b1; na = 0; wi = 0; ri = 0; busy = 0; ncmd = 0; dout = 16'h5A5A;
    for (int i = 0; i < 16; i++) mem[i] = 16'hA000 + 16'(i);
  end
  assign rb_n = (busy == 0);
  always @(posedge clk) begin
    we_q <= we_n;
    re_q <= re_n;
    // busy time runs on whatever ce does
    if (busy > 0) busy <= busy - 1;
    if (we_n && !we_q && !ce_n) begin
      if (cle && !ale && (busy == 0 || io[7:0] == 8'h70 || io[7:0] == 8'h78)) begin
        cmd <= io[7:0];
        ncmd <= ncmd + 1;
        na <= 0;
        if (io[7:0] == 8'hFF) busy <= BUSY;
        if (io[7:0] == 8'h00) ri <= 0;
        if (io[7:0] == 8'h30) busy <= 8;
        if (io[7:0] == 8'h80) wi <= 0;
        if (io[7:0] == 8'h10 && wp_n) busy <= BUSY;
      end
      // addresses that follow the enhanced status command get in while busy
      if (ale && !cle && (busy == 0 || cmd == 8'h78) && na < 5) begin
        adr[na] <= io[7:0];
        na <= na + 1;
      end
      if (!ale && !cle && busy == 0 && wi < 16) begin
        mem[wi] <= io;
        wi <= wi + 1;
      end
    end
    if (!re_n && re_q && !ce_n && we_n) begin
      if (cmd == 8'h70 || cmd == 8'h78) dout <= {8'h00, wp_n, busy == 0, 6'h00};
      else if (busy == 0) begin
        dout <= mem[ri[3:0]];
        ri <= ri + 1;
      end
    // released lines keep changing so a late sample cannot match
    end else if (re_n && re_q) dout <= ~dout;
  end
endmodule // nbh_flash_model
`default_nettype wire

// >>> test/nand_async_bus_interface_test.sv
// self-checking bench for the nand host controller
`timescale 1ns/1ps
`default_nettype none
module nand_async_bus_interface_test;
  logic        sys_clk, rstn, req_valid, req_last, wr_valid, rd_ready, addr_go, wp_allow;
  logic [1:0]  req_op;
  logic [7:0]  req_byte;
  logic [15:0] wr_data;
  logic [11:0] addr_col;
  logic [16:0] addr_blk;
  logic [5:0]  addr_page;
  wire logic   req_ready, wr_ready, rd_valid, init_done, target_ready, plane_sel, nand_rb_n;
  wire logic   nand_ce_n, nand_cle, nand_ale, nand_we_n, nand_re_n, nand_wp_n, nand_io_oe_n;
  wire logic [15:0] rd_data, nand_io_out, nand_io_in, m_dout;
  logic [7:0]  aexp [0:4];
  int          bad_count, total_checks;
  assign nand_io_in = nand_io_oe_n ? m_dout : nand_io_out;
  nbh_host #(.X16(1), .CYC_RST(50), .CYC_PWR(20), .FIFO_DEP(16)) nbh_host_i (.sys_clk, .rstn, .req_valid,
    .req_ready, .req_op, .req_byte, .req_last, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_ready,
    .addr_col, .addr_blk, .addr_page, .addr_go, .wp_allow, .init_done, .target_ready, .plane_sel, .nand_ce_n,
    .nand_cle, .nand_ale, .nand_we_n, .nand_re_n, .nand_wp_n, .nand_io_out, .nand_io_oe_n, .nand_io_in,
    .nand_rb_n);
  nbh_flash_model #(.BUSY(40)) nbh_flash_model_i (.clk(sys_clk), .ce_n(nand_ce_n), .cle(nand_cle),
    .ale(nand_ale), .we_n(nand_we_n), .re_n(nand_re_n), .wp_n(nand_wp_n), .io(nand_io_in), .dout(m_dout),
    .rb_n(nand_rb_n));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return req_ready;
      1: return nand_ce_n;
      2: return target_ready;
      3: return !target_ready;
      4: return init_done;
      5: return nand_wp_n;
      default: return rd_valid;
    endcase
  endfunction
  // bounded wait; a run-out counts against the run and ends it
  task automatic await(input int k, input int lim);
    int n;
    n = 0;
    while (sel(k) !== 1'b1) begin
      tick;
      n++;
      if (n > lim) begin
        bad_count++;
        $display("FAIL wait %0d expected 1 seen 0", k);
        complete_run;
      end
    end
  endtask
  task automatic send(input logic [1:0] o, input logic [15:0] b, input logic l);
    tick;
    req_op = o; req_byte = b[7:0]; wr_data = b; wr_valid = (o == 2'h2); req_last = l; req_valid = 1'b1;
    #1;
    await(0, 400);
    if (o == 2'h2) chk("write ready", wr_ready, 1'b1);
    tick;
    req_valid = 1'b0;
    wr_valid = 1'b0;
  endtask
  task automatic go_addr(input logic [11:0] c, input logic [16:0] bk, input logic [5:0] p);
    tick;
    addr_col = c; addr_blk = bk; addr_page = p; addr_go = 1'b1;
    #1;
    await(0, 400);
    tick;
    addr_go = 1'b0;
  endtask
  task automatic t_init;
    await(4, 2000);
    chk("first command", nbh_flash_model_i.cmd, 16'h00FF);
    chk("command count", 16'(nbh_flash_model_i.ncmd), 16'h0001);
    chk("protect at init", nand_wp_n, 1'b0);
    chk("ce released after reset", nand_ce_n, 1'b1);
    $display("test init done");
  endtask
  task automatic t_status;
    send(2'h0, 16'h0070, 1'b0);
    send(2'h3, 16'h0000, 1'b1);
    await(6, 100);
    chk("status word", rd_data, 16'h0040);
    rd_ready = 1'b1;
    tick;
    rd_ready = 1'b0;
    $display("test status done");
  endtask
  // column bit 11 lies outside the word-wide space and must be dropped
  task automatic t_addr_blocked;
    aexp = '{8'h1F, 8'h04, 8'h6A, 8'h5A, 8'h01};
    send(2'h0, 16'h0080, 1'b0);
    go_addr(12'hC1F, 17'h15A40, 6'h2A);
    send(2'h2, 16'h1111, 1'b0);
    send(2'h0, 16'h0010, 1'b1);
    await(1, 100);
    for (int i = 0; i < 5; i++) chk("address byte", nbh_flash_model_i.adr[i], aexp[i]);
    chk("plane select", plane_sel, 1'b1);
    repeat (10) tick;
    chk("ready while protected", target_ready, 1'b1);
    $display("test address done");
  endtask
  task automatic t_program;
    wp_allow = 1'b1;
    await(5, 200);
    chk("protect released", nand_wp_n, 1'b1);
    send(2'h0, 16'h0080, 1'b0);
    go_addr(12'h000, 17'h00000, 6'h00);
    send(2'h2, 16'h2222, 1'b0);
    send(2'h2, 16'h3333, 1'b0);
    send(2'h0, 16'h0010, 1'b1);
    await(3, 100);
    await(2, 200);
    chk("plane select", plane_sel, 1'b0);
    chk("cache word", nbh_flash_model_i.mem[1], 16'h3333);
    $display("test program done");
  endtask
  task automatic t_fifo;
    int i, n;
    send(2'h0, 16'h0000, 1'b0);
    go_addr(12'h000, 17'h00000, 6'h00);
    send(2'h0, 16'h0030, 1'b1);
    await(3, 100);
    await(2, 200);
    for (int k = 0; k < 16; k++) send(2'h3, 16'h0000, k == 15);
    // back in idle with the sixteenth word stored, so only a full fifo can refuse
    await(1, 100);
    tick;
    req_op = 2'h3;
    req_valid = 1'b1;
    #1;
    chk("full refuses read", req_ready, 1'b0);
    tick;
    req_valid = 1'b0;
    i = 0;
    n = 0;
    while (i < 16 && n < 400) begin
      tick;
      n++;
      if (rd_valid === 1'b1) begin
        chk("read word", rd_data, i == 0 ? 16'h2222 : i == 1 ? 16'h3333 : 16'hA000 + 16'(i));
        i++;
        rd_ready = 1'b1;
      end else rd_ready = 1'b0;
    end
    chk("words drained", 16'(i), 16'h0010);
    tick;
    rd_ready = 1'b0;
    chk("fifo empty", rd_valid, 1'b0);
    $display("test fifo done");
  endtask
  initial begin
    rstn = 1'b0; req_valid = 1'b0; req_last = 1'b0; wr_valid = 1'b0; rd_ready = 1'b0; addr_go = 1'b0;
    wp_allow = 1'b0; req_op = 2'h0; req_byte = 8'h00; wr_data = 16'h0000; addr_col = 12'h000;
    addr_blk = 17'h00000; addr_page = 6'h00; bad_count = 0; total_checks = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    t_init;
    t_status;
    t_addr_blocked;
    t_program;
    t_fifo;
    complete_run;
  end
endmodule // nand_async_bus_interface_test
bind nbh_host nbh_sva nbh_sva_i (.sys_clk, .rstn, .req_valid, .req_ready, .req_op, .init_done, .nand_ce_n,
  .nand_cle, .nand_ale, .nand_we_n, .nand_re_n, .nand_wp_n, .nand_io_out, .nand_io_oe_n);
`default_nettype wire
